// ### rtl/acr_pkg.sv
// Constants, register map and rate tables for the converter clock and rate control
package acr_pkg;

	// ------------------------------------------------------------------
	// Bus and register map
	// ------------------------------------------------------------------
	localparam int          ACR_ADDR_W       = 12;
	localparam logic [11:0] ACR_ADDR_REF     = 12'h000;
	localparam logic [11:0] ACR_ADDR_RATE    = 12'h004;
	localparam logic [11:0] ACR_ADDR_CTRL    = 12'h008;
	localparam logic [11:0] ACR_ADDR_STATUS  = 12'h00c;
	localparam logic [11:0] ACR_ADDR_OSR     = 12'h010;
	localparam logic [11:0] ACR_ADDR_COUNT   = 12'h014;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int ACR_REF_NBUF_BIT  = 0;
	localparam int ACR_REF_PBUF_BIT  = 1;
	localparam int ACR_REF_SEL_LSB   = 2;
	localparam int ACR_RATE_CODE_LSB = 0;
	localparam int ACR_RATE_CLK_BIT  = 4;
	localparam int ACR_CTRL_START    = 0;
	localparam int ACR_CTRL_CONT     = 1;
	localparam int ACR_CTRL_STOP     = 2;
	localparam int ACR_CTRL_RESET    = 3;
	localparam int ACR_ST_BUSY       = 0;
	localparam int ACR_ST_DRDY       = 1;
	localparam int ACR_ST_FIRST      = 2;
	localparam int ACR_ST_N50        = 3;
	localparam int ACR_ST_N60        = 4;

	// ------------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------------
	localparam logic [3:0]  ACR_REF_RST       = 4'h3;
	localparam logic [3:0]  ACR_RATE_RST      = 4'h4;
	localparam logic [3:0]  ACR_RATE_MAX      = 4'hd;
	localparam logic [1:0]  ACR_REFSEL_EXT0   = 2'h0;
	localparam logic [1:0]  ACR_REFSEL_EXT1   = 2'h1;
	localparam logic [1:0]  ACR_REFSEL_INT    = 2'h2;
	localparam logic [3:0]  ACR_DIV_LAST      = 4'hf;
	localparam logic [15:0] ACR_NOTCH50_MASK  = 16'h003f;
	localparam logic [15:0] ACR_NOTCH60_MASK  = 16'h0057;

	// ------------------------------------------------------------------
	// Oversampling ratio and first-result length per rate code
	// ------------------------------------------------------------------
	localparam logic [16:0] ACR_OSR_TABLE [0:13] = '{
		17'h19000, 17'h0c800, 17'h06400, 17'h03c00, 17'h03200, 17'h01400, 17'h010a8,
		17'h00a00, 17'h00500, 17'h00280, 17'h00140, 17'h00100, 17'h00080, 17'h00040};
	localparam logic [16:0] ACR_FIRST_TABLE [0:13] = '{
		17'h1968f, 17'h0ce8f, 17'h06a8f, 17'h03c4f, 17'h0388f, 17'h01436, 17'h010f7,
		17'h00a36, 17'h00536, 17'h002b6, 17'h00176, 17'h00136, 17'h000b6, 17'h00076};

	typedef enum logic [0:0]
	{
		ACR_IDLE    = 1'b0,
		ACR_CONVERT = 1'b1
	} acr_state_t;

endpackage

// ### rtl/acr_rate_if.sv
// Rate lookup signals between the control core and the rate table
`timescale 1ns/100ps
interface acr_rate_if;
	logic [3:0]  rate_code;
	logic [16:0] osr;
	logic [16:0] first_count;
	logic        notch_50hz;
	logic        notch_60hz;

	modport core (output rate_code, input osr, input first_count, input notch_50hz,
		input notch_60hz);
	modport rom (input rate_code, output osr, output first_count, output notch_50hz,
		output notch_60hz);
endinterface

// ### rtl/acr_rate_rom.sv
// Registered lookup of oversampling ratio, first-result length and line notches
`timescale 1ns/100ps
module acr_rate_rom
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Lookup port
	acr_rate_if.rom        rif
);

	// ------------------------------------------------------------------
	// Table read, one cycle latency
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rif.osr         <= ACR_OSR_TABLE[ACR_RATE_RST];
			rif.first_count <= ACR_FIRST_TABLE[ACR_RATE_RST];
			rif.notch_50hz  <= ACR_NOTCH50_MASK[ACR_RATE_RST];
			rif.notch_60hz  <= ACR_NOTCH60_MASK[ACR_RATE_RST];
		end
		else if (rif.rate_code <= ACR_RATE_MAX)
		begin
			rif.osr         <= ACR_OSR_TABLE[rif.rate_code];
			rif.first_count <= ACR_FIRST_TABLE[rif.rate_code];
			rif.notch_50hz  <= ACR_NOTCH50_MASK[rif.rate_code];
			rif.notch_60hz  <= ACR_NOTCH60_MASK[rif.rate_code];
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_osr_lookup;
		@(posedge pclk) disable iff (!presetn)
		(rif.rate_code <= ACR_RATE_MAX) |=> (rif.osr == ACR_OSR_TABLE[$past(rif.rate_code)]);
	endproperty
	a_osr_lookup: assert property (p_osr_lookup) else $error("osr does not match code");

endmodule

// ### rtl/acr_top.sv
// Reference selection, clock source, modulator divider and rate control core
//
// Overview of operation
// - Each reference buffer has its own off bit, where 1 switches the buffer off and 0 on.
// - Software picks external reference pair 0 or pair 1, pair 1 sharing analog input pins.
// - A bit in the rate register picks the internal oscillator or the external clock.
// - Power-up and any reset, by pin or command, return the clock to the internal oscillator.
// - The modulator clock is the selected system clock divided by sixteen.
// - The four-bit rate code sets the ratio, one result per ratio of modulator periods.
// - Codes 0 to 13 map to ratios 102400 down to 64 as tabulated.
// - The output rate follows the selected clock frequency in proportion.
// - The filter gives a settled result within a single conversion.
// - Notch flags show 50 and 60 Hz rejection for the rate in use.
// - Reference select value 10 routes the internal reference to the converter.
// - The first result after a start takes the longer first-result period count.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module acr_top
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ACR_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// System clock sources, one-cycle ticks
	input  wire logic                  int_osc_tick,
	input  wire logic                  ext_clk_tick,
	// Reference control
	output logic                       pos_ref_buffer_off,
	output logic                       neg_ref_buffer_off,
	output logic      [1:0]            reference_select,
	output logic                       ref_use_ext0,
	output logic                       ref_use_ext1,
	output logic                       ref_use_internal,
	// Clock and conversion status
	output logic                       ext_clk_selected,
	output logic                       mod_clk_tick,
	output logic                       sample_strobe,
	output logic                       conv_busy,
	output logic                       notch_50hz,
	output logic                       notch_60hz
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	acr_rate_if rif ();

	logic [3:0]  ref_ctrl_reg;
	logic [3:0]  rate_code_reg;
	logic        ext_sel_reg;
	logic        cont_reg;
	logic [3:0]  div_cnt_reg;
	logic [16:0] mod_cnt_reg;
	logic        first_reg;
	logic        drdy_reg;
	logic [15:0] samp_cnt_reg;
	logic [31:0] prdata_reg;
	logic        mod_tick_reg;
	logic        strobe_reg;
	acr_state_t  state_reg;

	logic        wr_access, rd_setup, rd_access, addr_hit;
	logic        wr_ref, wr_rate, wr_ctrl;
	logic        cmd_start, cmd_stop, cmd_reset, rate_valid;
	logic        sel_tick, mod_tick, conv_done, restart;
	logic [16:0] target;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	always_comb
	begin
		case (paddr)
			ACR_ADDR_REF, ACR_ADDR_RATE, ACR_ADDR_CTRL,
			ACR_ADDR_STATUS, ACR_ADDR_OSR, ACR_ADDR_COUNT: addr_hit = 1'b1;
			default:                                       addr_hit = 1'b0;
		endcase
	end

	assign wr_access  = psel & penable & pwrite & addr_hit;
	assign rd_setup   = psel & ~penable & ~pwrite;
	assign rd_access  = psel & penable & ~pwrite;
	assign wr_ref     = wr_access & (paddr == ACR_ADDR_REF);
	assign wr_rate    = wr_access & (paddr == ACR_ADDR_RATE);
	assign wr_ctrl    = wr_access & (paddr == ACR_ADDR_CTRL);
	assign cmd_start  = wr_ctrl & pwdata[ACR_CTRL_START];
	assign cmd_stop   = wr_ctrl & pwdata[ACR_CTRL_STOP];
	assign cmd_reset  = wr_ctrl & pwdata[ACR_CTRL_RESET];
	assign rate_valid = pwdata[ACR_RATE_CODE_LSB+:4] <= ACR_RATE_MAX;

	// Zero wait states, error on unmapped address
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign prdata  = prdata_reg;

	// ------------------------------------------------------------------
	// Reference control register
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ref_ctrl_reg <= ACR_REF_RST;
		else if (cmd_reset)
			ref_ctrl_reg <= ACR_REF_RST;
		else if (wr_ref)
			ref_ctrl_reg <= pwdata[3:0];
	end

	// Buffer off bits, active low enables
	assign pos_ref_buffer_off = ref_ctrl_reg[ACR_REF_PBUF_BIT];
	assign neg_ref_buffer_off = ref_ctrl_reg[ACR_REF_NBUF_BIT];
	assign reference_select   = ref_ctrl_reg[ACR_REF_SEL_LSB+:2];

	// Reference multiplexer, reserved value 11 falls back to pair 0
	always_comb
	begin
		ref_use_ext0     = 1'b0;
		ref_use_ext1     = 1'b0;
		ref_use_internal = 1'b0;
		case (reference_select)
			ACR_REFSEL_EXT1: ref_use_ext1     = 1'b1;
			ACR_REFSEL_INT:  ref_use_internal = 1'b1;
			default:         ref_use_ext0     = 1'b1;
		endcase
	end

	// ------------------------------------------------------------------
	// Rate register and clock source
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rate_code_reg <= ACR_RATE_RST;
		else if (cmd_reset)
			rate_code_reg <= ACR_RATE_RST;
		else if (wr_rate && rate_valid)
			rate_code_reg <= pwdata[ACR_RATE_CODE_LSB+:4];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_sel_reg <= 1'b0;
		else if (cmd_reset)
			ext_sel_reg <= 1'b0;
		else if (wr_rate)
			ext_sel_reg <= pwdata[ACR_RATE_CLK_BIT];
	end

	assign ext_clk_selected = ext_sel_reg;
	assign rif.rate_code    = rate_code_reg;
	assign notch_50hz       = rif.notch_50hz;
	assign notch_60hz       = rif.notch_60hz;

	acr_rate_rom u_rom
	(
		.pclk    (pclk),
		.presetn (presetn),
		.rif     (rif.rom)
	);

	// ------------------------------------------------------------------
	// Modulator clock divider
	// ------------------------------------------------------------------
	assign sel_tick = ext_sel_reg ? ext_clk_tick : int_osc_tick;
	assign mod_tick = sel_tick && (div_cnt_reg == ACR_DIV_LAST);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_reg <= '0;
		else if (cmd_reset)
			div_cnt_reg <= '0;
		else if (sel_tick)
			div_cnt_reg <= div_cnt_reg + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mod_tick_reg <= 1'b0;
		else
			mod_tick_reg <= mod_tick;
	end

	assign mod_clk_tick = mod_tick_reg;

	// ------------------------------------------------------------------
	// Conversion sequencing
	// ------------------------------------------------------------------
	assign target    = first_reg ? rif.first_count : rif.osr;
	assign conv_done = (state_reg == ACR_CONVERT) && mod_tick
		&& (mod_cnt_reg == 17'(target - 17'h1));
	assign restart   = cmd_start || cmd_reset || (wr_rate && state_reg == ACR_CONVERT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= ACR_IDLE;
		else if (cmd_reset || cmd_stop)
			state_reg <= ACR_IDLE;
		else if (cmd_start)
			state_reg <= ACR_CONVERT;
		else
		begin
			case (state_reg)
				ACR_IDLE:    state_reg <= ACR_IDLE;
				ACR_CONVERT: if (conv_done && !cont_reg) state_reg <= ACR_IDLE;
				default:     state_reg <= ACR_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cont_reg <= 1'b0;
		else if (cmd_reset)
			cont_reg <= 1'b0;
		else if (wr_ctrl)
			cont_reg <= pwdata[ACR_CTRL_CONT];
	end

	// Modulator period count, each result built from fresh periods only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mod_cnt_reg <= '0;
		else if (restart || cmd_reset || conv_done)
			mod_cnt_reg <= '0;
		else if (state_reg == ACR_CONVERT && mod_tick)
			mod_cnt_reg <= mod_cnt_reg + 17'h1;
	end

	// First result after a start or a rate change runs longer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_reg <= 1'b1;
		else if (restart || cmd_reset)
			first_reg <= 1'b1;
		else if (conv_done)
			first_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			strobe_reg <= 1'b0;
		else
			strobe_reg <= conv_done && !restart;
	end

	assign sample_strobe = strobe_reg;
	assign conv_busy     = (state_reg == ACR_CONVERT);

	// Result ready flag, a new result wins over the read clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drdy_reg <= 1'b0;
		else if (conv_done && !restart)
			drdy_reg <= 1'b1;
		else if (cmd_reset || (rd_access && paddr == ACR_ADDR_STATUS))
			drdy_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			samp_cnt_reg <= '0;
		else if (cmd_reset)
			samp_cnt_reg <= '0;
		else if (conv_done && !restart)
			samp_cnt_reg <= samp_cnt_reg + 16'h1;
	end

	// ------------------------------------------------------------------
	// Read data, captured in the setup phase
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= '0;
		else if (rd_setup)
		begin
			prdata_reg <= '0;
			case (paddr)
				ACR_ADDR_REF:    prdata_reg[3:0] <= ref_ctrl_reg;
				ACR_ADDR_RATE:   prdata_reg[4:0] <= {ext_sel_reg, rate_code_reg};
				ACR_ADDR_CTRL:   prdata_reg[ACR_CTRL_CONT] <= cont_reg;
				ACR_ADDR_STATUS: prdata_reg[4:0] <= {rif.notch_60hz, rif.notch_50hz,
					first_reg, drdy_reg, conv_busy};
				ACR_ADDR_OSR:    prdata_reg[16:0] <= rif.osr;
				ACR_ADDR_COUNT:  prdata_reg[15:0] <= samp_cnt_reg;
				default:         prdata_reg <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rate_write_bad;
		wr_rate && !rate_valid && !cmd_reset;
	endsequence
	sequence s_start_cmd;
		cmd_start && !cmd_reset && !cmd_stop;
	endsequence
	property p_pbuf;
		wr_ref && !cmd_reset |=> pos_ref_buffer_off == $past(pwdata[ACR_REF_PBUF_BIT]);
	endproperty
	a_pbuf: assert property (p_pbuf) else $error("pos buffer bit not taken");
	property p_refsel_int;
		reference_select == ACR_REFSEL_INT |-> ref_use_internal && !ref_use_ext0
			&& !ref_use_ext1;
	endproperty
	a_refsel_int: assert property (p_refsel_int) else $error("internal ref not routed");
	property p_refsel_ext1;
		wr_ref && pwdata[ACR_REF_SEL_LSB+:2] == ACR_REFSEL_EXT1 |=> ref_use_ext1 && !ref_use_ext0;
	endproperty
	a_refsel_ext1: assert property (p_refsel_ext1) else $error("pair 1 not routed");
	property p_clk_sel;
		wr_rate && !cmd_reset |=> ext_clk_selected == $past(pwdata[ACR_RATE_CLK_BIT]);
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("clock source not taken");
	property p_clk_reset;
		cmd_reset |=> !ext_clk_selected && rate_code_reg == ACR_RATE_RST;
	endproperty
	a_clk_reset: assert property (p_clk_reset) else $error("reset kept external clock");
	property p_div16;
		mod_tick |=> div_cnt_reg == 4'h0 ##0 mod_clk_tick;
	endproperty
	a_div16: assert property (p_div16) else $error("divider not by sixteen");
	property p_bad_rate;
		s_rate_write_bad |=> $stable(rate_code_reg);
	endproperty
	a_bad_rate: assert property (p_bad_rate) else $error("invalid rate accepted");
	property p_done_count;
		conv_done |-> mod_tick && mod_cnt_reg == 17'((first_reg ? ACR_FIRST_TABLE[rate_code_reg]
			: ACR_OSR_TABLE[rate_code_reg]) - 17'h1);
	endproperty
	a_done_count: assert property (p_done_count) else $error("result at wrong count");
	property p_first;
		s_start_cmd |=> first_reg && conv_busy && mod_cnt_reg == 17'h0;
	endproperty
	a_first: assert property (p_first) else $error("start did not arm first result");
	property p_strobe;
		conv_done && !restart |=> sample_strobe && drdy_reg;
	endproperty
	a_strobe: assert property (p_strobe) else $error("result not flagged");
endmodule

// ### test/acr_tick_src.sv
// Clock source model: internal oscillator and external clock ticks
`timescale 1ns/100ps
module acr_tick_src
#(
	parameter int EXT_PERIOD = 3
)
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Tick outputs
	output logic      int_osc_tick,
	output logic      ext_clk_tick
);
	int ext_cnt;

	// Internal tick every cycle, external tick once per period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_osc_tick <= 1'b0;
			ext_clk_tick <= 1'b0;
			ext_cnt      <= 0;
		end
		else
		begin
			int_osc_tick <= 1'b1;
			ext_cnt      <= (ext_cnt == EXT_PERIOD - 1) ? 0 : ext_cnt + 1;
			ext_clk_tick <= (ext_cnt == EXT_PERIOD - 1);
		end
	end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the converter clock and rate control
`timescale 1ns/100ps
module tb_top
	import acr_pkg::*;
;
	logic                  pclk, presetn, psel, penable, pwrite;
	logic [ACR_ADDR_W-1:0] paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic                  pready, pslverr, int_osc_tick, ext_clk_tick;
	logic                  pos_ref_buffer_off, neg_ref_buffer_off, ref_use_ext0, ref_use_ext1;
	logic                  ref_use_internal, ext_clk_selected, mod_clk_tick, sample_strobe;
	logic                  conv_busy, notch_50hz, notch_60hz, err;
	logic [1:0]            reference_select;
	int                    n_mismatch, n_compared, n;
	int                    osr_exp [0:13] = '{102400, 51200, 25600, 15360, 12800, 5120, 4264,
		2560, 1280, 640, 320, 256, 128, 64};
	logic [15:0]           n50_exp = 16'h003f;
	logic [15:0]           n60_exp = 16'h0057;

	// ------------------------------------------------------------------
	// Design, tick source and clock
	// ------------------------------------------------------------------
	acr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .int_osc_tick(int_osc_tick), .ext_clk_tick(ext_clk_tick),
		.pos_ref_buffer_off(pos_ref_buffer_off), .neg_ref_buffer_off(neg_ref_buffer_off),
		.reference_select(reference_select), .ref_use_ext0(ref_use_ext0),
		.ref_use_ext1(ref_use_ext1), .ref_use_internal(ref_use_internal),
		.ext_clk_selected(ext_clk_selected), .mod_clk_tick(mod_clk_tick),
		.sample_strobe(sample_strobe), .conv_busy(conv_busy), .notch_50hz(notch_50hz),
		.notch_60hz(notch_60hz));
	acr_tick_src #(.EXT_PERIOD(3)) src (.pclk(pclk), .presetn(presetn),
		.int_osc_tick(int_osc_tick), .ext_clk_tick(ext_clk_tick));

	// Clock generation
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer: setup, then access until pready at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd  = prdata;
		err = pslverr;
		if (k >= 50)
			chk(32'h1, 32'h0);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Count modulator ticks up to the next result strobe
	task automatic wait_strobe(output int nmod);
		int k;
		nmod = 0;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
			if (mod_clk_tick === 1'b1)
				nmod++;
		end
		while (sample_strobe !== 1'b1 && k < 5000);
	endtask

	// Cycles between two modulator ticks
	task automatic mod_gap(output int gap);
		gap = 0;
		do @(posedge pclk); while (mod_clk_tick !== 1'b1);
		do
		begin
			@(posedge pclk);
			gap++;
		end
		while (mod_clk_tick !== 1'b1 && gap < 200);
	endtask

	task automatic pin_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Watchdog
	initial
	begin
		#500us;
		n_mismatch++;
		give_verdict();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = '0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values
		apb(1'b0, ACR_ADDR_REF, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, ACR_ADDR_RATE, 32'h0);
		chk(rd, 32'h4);
		chk({pos_ref_buffer_off, neg_ref_buffer_off, ext_clk_selected}, 32'h6);
		// Reference select and buffer bits
		for (int s = 0; s < 3; s++)
		begin
			apb(1'b1, ACR_ADDR_REF, 32'((s << 2) | (s & 1) | 2));
			@(posedge pclk);
			chk({ref_use_internal, ref_use_ext1, ref_use_ext0}, 32'(1 << s));
			chk({pos_ref_buffer_off, neg_ref_buffer_off}, 32'h2 | 32'(s & 1));
			chk(reference_select, 32'(s));
		end
		// Internal reference with both buffers off
		apb(1'b1, ACR_ADDR_REF, 32'hb);
		@(posedge pclk);
		chk({ref_use_internal, pos_ref_buffer_off, neg_ref_buffer_off}, 32'h7);
		// Ratio and notch per rate code
		for (int c = 0; c < 14; c++)
		begin
			apb(1'b1, ACR_ADDR_RATE, 32'(c));
			apb(1'b0, ACR_ADDR_OSR, 32'h0);
			chk(rd, 32'(osr_exp[c]));
			apb(1'b0, ACR_ADDR_STATUS, 32'h0);
			chk(rd[4:3], {n60_exp[c], n50_exp[c]});
			chk({notch_60hz, notch_50hz}, {n60_exp[c], n50_exp[c]});
		end
		// Reserved rate code keeps the previous one
		apb(1'b1, ACR_ADDR_RATE, 32'he);
		apb(1'b0, ACR_ADDR_RATE, 32'h0);
		chk(rd, 32'hd);
		// Unmapped address refused, nothing written
		apb(1'b1, 12'h018, 32'hffff_ffff);
		chk(err, 1'b1);
		apb(1'b0, 12'h018, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		// Modulator divide by sixteen, internal then external clock
		mod_gap(n);
		chk(n, 16);
		apb(1'b1, ACR_ADDR_RATE, 32'h1d);
		@(posedge pclk);
		chk(ext_clk_selected, 1'b1);
		mod_gap(n);
		mod_gap(n);
		chk(n, 48);
		// Command reset returns to internal oscillator
		apb(1'b1, ACR_ADDR_CTRL, 32'h8);
		@(posedge pclk);
		chk(ext_clk_selected, 1'b0);
		apb(1'b0, ACR_ADDR_RATE, 32'h0);
		chk(rd, 32'h4);
		// Pin reset in mid-run does the same
		apb(1'b1, ACR_ADDR_RATE, 32'h1d);
		@(posedge pclk);
		chk(ext_clk_selected, 1'b1);
		pin_reset();
		@(posedge pclk);
		chk(ext_clk_selected, 1'b0);
		// Continuous conversion at the fastest code
		apb(1'b1, ACR_ADDR_RATE, 32'hd);
		apb(1'b1, ACR_ADDR_CTRL, 32'h3);
		wait_strobe(n);
		chk(n >= 118 && n <= 119, 1'b1);
		chk(conv_busy, 1'b1);
		wait_strobe(n);
		chk(n, 64);
		apb(1'b1, ACR_ADDR_CTRL, 32'h4);
		@(posedge pclk);
		chk(conv_busy, 1'b0);
		apb(1'b0, ACR_ADDR_COUNT, 32'h0);
		chk(rd[15:0], 16'h2);
		apb(1'b0, ACR_ADDR_STATUS, 32'h0);
		chk(rd[1], 1'b1);
		apb(1'b0, ACR_ADDR_STATUS, 32'h0);
		chk(rd[1], 1'b0);
		// Single conversion returns to idle after one result
		apb(1'b1, ACR_ADDR_CTRL, 32'h1);
		wait_strobe(n);
		chk(n >= 118 && n <= 119, 1'b1);
		chk(conv_busy, 1'b0);
		apb(1'b0, ACR_ADDR_COUNT, 32'h0);
		chk(rd[15:0], 16'h3);
		give_verdict();
	end
endmodule
